// File: mem_size_if.sv
`timescale 1ns/100ps
interface mem_size_if;
   logic [2:0] highspeedRamSizeField;
   logic [3:0] programStoreSizeField;
   logic [4:0] expansionRamSizeField;

   modport owner (
      output highspeedRamSizeField,
      output programStoreSizeField,
      output expansionRamSizeField
   );
   modport decoder (
      input highspeedRamSizeField,
      input programStoreSizeField,
      input expansionRamSizeField
   );
endinterface

// File: memory_map_decoder.sv
`timescale 1ns/100ps
module memory_map_decoder
   import memory_size_config_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [15:0] busAddr,
   mem_size_if.decoder sizes,
   output logic romSel,
   output logic hsRamSel,
   output logic xRamSel,
   output logic sizeFault
);

   logic [15:0] romEnd;
   logic romOk;
   logic hsOk;
   logic xOk;

   // Prohibited codes map nothing rather than guess a size
   always_comb begin
      romEnd = 16'h0000;
      romOk = 1'b0;
      case (sizes.programStoreSizeField)
         ROM_CODE_48K: begin
            romEnd = ROM_END_48K;
            romOk = 1'b1;
         end
         ROM_CODE_60K: begin
            romEnd = ROM_END_60K;
            romOk = 1'b1;
         end
         default: begin
            romEnd = 16'h0000;
            romOk = 1'b0;
         end
      endcase
      hsOk = (sizes.highspeedRamSizeField == HSRAM_CODE_512);
      xOk = (sizes.expansionRamSizeField == XRAM_CODE_512);
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         romSel <= 1'b0;
         hsRamSel <= 1'b0;
         xRamSel <= 1'b0;
         sizeFault <= 1'b0;
      end else begin
         romSel <= romOk && (busAddr <= romEnd);
         hsRamSel <= hsOk && (busAddr >= HSRAM_BASE) &&
            (busAddr <= HSRAM_END);
         xRamSel <= xOk && (busAddr >= XRAM_BASE) &&
            (busAddr <= XRAM_END);
         sizeFault <= !(romOk && hsOk && xOk);
      end
   end

   a_rom_60k_edge: assert property (@(posedge core_clk) disable iff (!rst_n)
      (sizes.programStoreSizeField == ROM_CODE_60K && busAddr == 16'hefff)
      |=> romSel)
      else $error("60K store must cover efff");
   a_rom_48k_limit: assert property (@(posedge core_clk) disable iff (!rst_n)
      (sizes.programStoreSizeField == ROM_CODE_48K && busAddr == 16'hc000)
      |=> !romSel)
      else $error("48K store must end at bfff");
   a_hsram_window: assert property (@(posedge core_clk) disable iff (!rst_n)
      hsRamSel |-> $past(busAddr) >= 16'hfd00 && $past(busAddr) <= 16'hfeff
      && $past(sizes.highspeedRamSizeField) == 3'h2)
      else $error("High-speed RAM select outside its 512 bytes");
   a_xram_window: assert property (@(posedge core_clk) disable iff (!rst_n)
      xRamSel |-> $past(sizes.expansionRamSizeField) == 5'h0b)
      else $error("Expansion RAM selected under a prohibited code");

   c_rom_48k: cover property (@(posedge core_clk) disable iff (!rst_n)
      romSel && sizes.programStoreSizeField == ROM_CODE_48K);
   c_size_fault: cover property (@(posedge core_clk) disable iff (!rst_n)
      sizeFault);
endmodule

// File: memory_size_config_pkg.sv
package memory_size_config_pkg;

   localparam logic [15:0] MEMSIZE_ADDR = 16'hfff0;
   localparam logic [15:0] XRAMSIZE_ADDR = 16'hfff4;
   localparam logic [7:0] MEMSIZE_RESET = 8'hcf;
   localparam logic [7:0] XRAMSIZE_RESET = 8'h0c;
   localparam logic [7:0] MEMSIZE_KEEP_MASK = 8'hef;
   localparam logic [7:0] XRAMSIZE_KEEP_MASK = 8'h1f;

   localparam int HSRAM_FIELD_LSB = 5;
   localparam int HSRAM_FIELD_MSB = 7;
   localparam int ROM_FIELD_LSB = 0;
   localparam int ROM_FIELD_MSB = 3;
   localparam int XRAM_FIELD_LSB = 0;
   localparam int XRAM_FIELD_MSB = 4;

   localparam logic [2:0] HSRAM_CODE_512 = 3'h2;
   localparam logic [3:0] ROM_CODE_48K = 4'hc;
   localparam logic [3:0] ROM_CODE_60K = 4'hf;
   localparam logic [4:0] XRAM_CODE_512 = 5'h0b;

   localparam logic [15:0] ROM_END_48K = 16'hbfff;
   localparam logic [15:0] ROM_END_60K = 16'hefff;
   localparam logic [15:0] HSRAM_BASE = 16'hfd00;
   localparam logic [15:0] HSRAM_END = 16'hfeff;
   localparam logic [15:0] XRAM_BASE = 16'hf400;
   localparam logic [15:0] XRAM_END = 16'hf5ff;

endpackage

// File: memory_size_config_regs.sv
`timescale 1ns/100ps
module memory_size_config_regs
   import memory_size_config_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [15:0] busAddr,
   input wire logic [7:0] busWrData,
   input wire logic busWrEn,
   input wire logic busRdEn,
   output logic [7:0] busRdData,
   output logic regHit,
   output logic romSel,
   output logic hsRamSel,
   output logic xRamSel,
   output logic sizeFault
);

   logic [7:0] internalMemorySizeSel;
   logic [7:0] expansionRamSizeSel;
   logic memSizeHit;
   logic xramSizeHit;

   mem_size_if sizes ();

   assign memSizeHit = (busAddr == MEMSIZE_ADDR);
   assign xramSizeHit = (busAddr == XRAMSIZE_ADDR);

   // Whole-byte writes only; the bus carries no byte lane or bit op
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         internalMemorySizeSel <= MEMSIZE_RESET;
      end else if (busWrEn && memSizeHit) begin
         internalMemorySizeSel <= busWrData & MEMSIZE_KEEP_MASK;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         expansionRamSizeSel <= XRAMSIZE_RESET;
      end else if (busWrEn && xramSizeHit) begin
         expansionRamSizeSel <= busWrData & XRAMSIZE_KEEP_MASK;
      end
   end

   // Other addresses belong to other blocks, so they read zero here
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         busRdData <= 8'h00;
         regHit <= 1'b0;
      end else begin
         regHit <= memSizeHit || xramSizeHit;
         if (busRdEn && memSizeHit) begin
            busRdData <= internalMemorySizeSel;
         end else if (busRdEn && xramSizeHit) begin
            busRdData <= expansionRamSizeSel;
         end else begin
            busRdData <= 8'h00;
         end
      end
   end

   assign sizes.highspeedRamSizeField =
      internalMemorySizeSel[HSRAM_FIELD_MSB:HSRAM_FIELD_LSB];
   assign sizes.programStoreSizeField =
      internalMemorySizeSel[ROM_FIELD_MSB:ROM_FIELD_LSB];
   assign sizes.expansionRamSizeField =
      expansionRamSizeSel[XRAM_FIELD_MSB:XRAM_FIELD_LSB];

   memory_map_decoder mapDecoder (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .busAddr(busAddr),
      .sizes(sizes.decoder),
      .romSel(romSel),
      .hsRamSel(hsRamSel),
      .xRamSel(xRamSel),
      .sizeFault(sizeFault)
   );

   a_memsize_reset_val: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      $rose(rst_n) |-> internalMemorySizeSel == 8'hcf)
      else $error("Memory size register not cf after reset");
   a_xramsize_reset_val: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      $rose(rst_n) |-> expansionRamSizeSel == 8'h0c)
      else $error("Expansion size register not 0c after reset");
   a_memsize_write_store: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      busWrEn && busAddr == 16'hfff0 |=>
      internalMemorySizeSel == ($past(busWrData) & 8'hef))
      else $error("Memory size register missed a write");
   a_memsize_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      !(busWrEn && busAddr == 16'hfff0) |=> $stable(internalMemorySizeSel))
      else $error("Memory size register changed without a write");
   a_unused_bits_zero: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      internalMemorySizeSel[4] == 1'b0 &&
      expansionRamSizeSel[7:5] == 3'h0)
      else $error("Unused size bits not zero");
   a_xramsize_read_back: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      busRdEn && busAddr == 16'hfff4 && !busWrEn |=>
      busRdData == $past(expansionRamSizeSel))
      else $error("Expansion size register read wrong");
   // Probe address follows the write after one idle bus cycle
   a_memsize_to_decode: assert property (@(posedge core_clk)
      disable iff (!rst_n)
      busWrEn && busAddr == 16'hfff0 && busWrData == 8'h4c ##2
      busAddr == 16'hc000 |=> !romSel)
      else $error("Writing 4c did not shrink the program store");

   c_write_small: cover property (@(posedge core_clk) disable iff (!rst_n)
      busWrEn && memSizeHit && busWrData == 8'h4c);
   c_write_large: cover property (@(posedge core_clk) disable iff (!rst_n)
      busWrEn && memSizeHit && busWrData == 8'h4f);
   c_write_xram: cover property (@(posedge core_clk) disable iff (!rst_n)
      busWrEn && xramSizeHit && busWrData == 8'h0b);
endmodule

// File: memory_size_config_regs_tb.sv
`timescale 1ns/100ps
module memory_size_config_regs_tb import memory_size_config_pkg::*;;
   logic core_clk, rst_n, busWrEn, busRdEn;
   logic [15:0] busAddr;
   logic [7:0] busWrData, busRdData;
   logic regHit, romSel, hsRamSel, xRamSel, sizeFault;
   int nErrors, checked, memSizeModel, xramSizeModel;
   logic [31:0] seed;
   logic [15:0] cfgs [4] = '{16'h4c0b, 16'h4f0b, 16'hffff, 16'h4f1b};
   logic [15:0] addrs [10] = '{16'h0000, 16'hbfff, 16'hc000, 16'hefff,
      16'hf000, 16'hf400, 16'hf5ff, 16'hfd00, 16'hfeff, 16'hff00};

   memory_size_config_regs i_memory_size_config_regs (.core_clk(core_clk),
      .rst_n(rst_n), .busAddr(busAddr), .busWrData(busWrData),
      .busWrEn(busWrEn), .busRdEn(busRdEn), .busRdData(busRdData),
      .regHit(regHit), .romSel(romSel), .hsRamSel(hsRamSel),
      .xRamSel(xRamSel), .sizeFault(sizeFault));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         nErrors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task stop_test;
      $display("comparisons %0d mismatches %0d", checked, nErrors);
      if (nErrors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      busAddr <= a;
      busWrData <= d;
      busWrEn <= 1'b1; // Whole-byte writes only
      @(posedge core_clk);
      busWrEn <= 1'b0;
      // Unused bits never store
      if (a == MEMSIZE_ADDR) memSizeModel = d & 8'hef;
      if (a == XRAMSIZE_ADDR) xramSizeModel = d & 8'h1f;
   endtask

   task automatic rd(input logic [15:0] a);
      int e;
      logic hit;
      hit = (a == MEMSIZE_ADDR) || (a == XRAMSIZE_ADDR);
      e = (a == MEMSIZE_ADDR) ? memSizeModel :
         (a == XRAMSIZE_ADDR) ? xramSizeModel : 0;
      @(posedge core_clk);
      busAddr <= a;
      busRdEn <= 1'b1;
      @(posedge core_clk);
      busRdEn <= 1'b0;
      #1;
      chk(busRdData, e[7:0]);
      chk({7'h00, regHit}, {7'h00, hit});
   endtask

   task automatic dec(input logic [15:0] a);
      int r, h, x, f;
      @(posedge core_clk);
      busAddr <= a;
      @(posedge core_clk);
      #1;
      r = (memSizeModel[3:0] == 4'hc && a <= 16'hbfff) ||
         (memSizeModel[3:0] == 4'hf && a <= 16'hefff);
      h = memSizeModel[7:5] == 3'h2;
      x = xramSizeModel[4:0] == 5'h0b;
      f = !(h && x &&
         (memSizeModel[3:0] == 4'hc || memSizeModel[3:0] == 4'hf));
      h = h && a >= 16'hfd00 && a <= 16'hfeff;
      x = x && a >= 16'hf400 && a <= 16'hf5ff;
      chk({7'h00, romSel}, {7'h00, r[0]});
      chk({7'h00, hsRamSel}, {7'h00, h[0]});
      chk({7'h00, xRamSel}, {7'h00, x[0]});
      chk({7'h00, sizeFault}, {7'h00, f[0]});
   endtask

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // Fixed latencies everywhere, so this only catches a stuck run
   initial begin
      #200000;
      nErrors++;
      stop_test;
   end

   initial begin
      rst_n = 1'b0;
      busAddr = 16'h0000;
      busWrData = 8'h00;
      busWrEn = 1'b0;
      busRdEn = 1'b0;
      memSizeModel = 8'hcf;
      xramSizeModel = 8'h0c;
      seed = 32'h5caf1ab1;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(MEMSIZE_ADDR);
      rd(XRAMSIZE_ADDR);
      rd(16'hfff2);
      foreach (addrs[i]) dec(addrs[i]);
      foreach (cfgs[c]) begin
         wr(MEMSIZE_ADDR, cfgs[c][15:8]);
         wr(XRAMSIZE_ADDR, cfgs[c][7:0]);
         rd(MEMSIZE_ADDR);
         rd(XRAMSIZE_ADDR);
         foreach (addrs[i]) dec(addrs[i]);
      end
      // Shrink then probe just past the 48K store after one idle cycle
      wr(MEMSIZE_ADDR, 8'h4c);
      dec(16'hc000);
      repeat (40) begin
         seed = xs(seed);
         wr(seed[8] ? MEMSIZE_ADDR : XRAMSIZE_ADDR, seed[7:0]);
         rd(seed[9] ? MEMSIZE_ADDR : XRAMSIZE_ADDR);
         dec({4'hf, seed[27:16]});
      end
      // Second reset in mid-run must bring back the load values
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      memSizeModel = 8'hcf;
      xramSizeModel = 8'h0c;
      rd(MEMSIZE_ADDR);
      rd(XRAMSIZE_ADDR);
      stop_test;
   end
endmodule
